// ===== inc/stp_defines.svh
`ifndef STP_DEFINES_SVH
`define STP_DEFINES_SVH

// general_timer_control location
`define STP_GTC_DATA_OFFSET 8'h43
`define STP_IO_SPACE_BASE 8'h20
`define STP_GTC_IO_OFFSET (`STP_GTC_DATA_OFFSET - `STP_IO_SPACE_BASE)
`define STP_GTC_RESET 8'h00

// general_timer_control fields
`define STP_GTC_SYNC_MODE_BIT 7
`define STP_GTC_ASYNC_BIT 1
`define STP_GTC_SYNC_BIT 0

// clock_select_field codes
`define STP_CS_STOP 3'h0
`define STP_CS_DIRECT 3'h1
`define STP_CS_DIV8 3'h2
`define STP_CS_DIV64 3'h3
`define STP_CS_DIV256 3'h4
`define STP_CS_DIV1024 3'h5
`define STP_CS_EXT_FALL 3'h6
`define STP_CS_EXT_RISE 3'h7

// divider tap positions (log2 of the ratio) and tap indices
`define STP_LOG2_DIV8 3
`define STP_LOG2_DIV64 6
`define STP_LOG2_DIV256 8
`define STP_LOG2_DIV1024 10
`define STP_TAP_DIV8 0
`define STP_TAP_DIV64 1
`define STP_TAP_DIV256 2
`define STP_TAP_DIV1024 3
`define STP_TAP_COUNT 4

`endif

// ===== inc/stp_pkg.sv
`include "stp_defines.svh"

package stp_pkg;

   typedef enum logic [2:0] {
      CS_STOP = `STP_CS_STOP,
      CS_DIRECT = `STP_CS_DIRECT,
      CS_DIV8 = `STP_CS_DIV8,
      CS_DIV64 = `STP_CS_DIV64,
      CS_DIV256 = `STP_CS_DIV256,
      CS_DIV1024 = `STP_CS_DIV1024,
      CS_EXT_FALL = `STP_CS_EXT_FALL,
      CS_EXT_RISE = `STP_CS_EXT_RISE
   } stp_clock_select_t;

   typedef logic [`STP_TAP_COUNT-1:0] stp_taps_t;

endpackage : stp_pkg

// ===== inc/stp_if.sv
`timescale 1ns/1ns
`default_nettype none

interface stp_if;
   stp_pkg::stp_taps_t tap;
   logic presc_reset;
   logic [1:0] pin_sync;
   logic [1:0] pin_prev;

   modport div (input presc_reset, output tap);
   modport ext (output pin_sync, output pin_prev);
   modport core (input tap, input pin_sync, input pin_prev, output presc_reset);
endinterface : stp_if

`default_nettype wire

// ===== verilog/stp_divider.sv
`timescale 1ns/1ns
`default_nettype none
`include "stp_defines.svh"

module stp_divider #(
   parameter int DIV_WIDTH = `STP_LOG2_DIV1024
) (
   input wire logic clk,
   input wire logic rst_n,
   stp_if.div link
);

   if (DIV_WIDTH < `STP_LOG2_DIV1024) begin : g_width_check
      $error("stp_divider: DIV_WIDTH too small for the /1024 tap");
   end

   logic [DIV_WIDTH-1:0] count_q;

   // free running, ignores every clock select
   // never aligned to a select change, so the first tap lands anywhere in 1..N+1
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (link.presc_reset) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + {{(DIV_WIDTH-1){1'b0}}, 1'b1};
      end
   end

   // one pulse per period, on the last count before wrap
   assign link.tap[`STP_TAP_DIV8] = &count_q[`STP_LOG2_DIV8-1:0];
   assign link.tap[`STP_TAP_DIV64] = &count_q[`STP_LOG2_DIV64-1:0];
   assign link.tap[`STP_TAP_DIV256] = &count_q[`STP_LOG2_DIV256-1:0];
   assign link.tap[`STP_TAP_DIV1024] = &count_q[`STP_LOG2_DIV1024-1:0];

endmodule : stp_divider

`default_nettype wire

// ===== verilog/stp_ext_sync.sv
`timescale 1ns/1ns
`default_nettype none

module stp_ext_sync #(
   parameter int IDX = 0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic pin,
   stp_if.ext link
);

   if (IDX < 0 || IDX > 1) begin : g_idx_check
      $error("stp_ext_sync: IDX must be 0 or 1");
   end

   logic pin_latch;
   logic sync1_q;
   logic sync2_q;
   logic prev_q;

   // open while the clock is high, holds while low
   always_latch begin
      if (clk) begin
         pin_latch <= pin;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         sync1_q <= pin_latch;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   assign link.pin_sync[IDX] = sync2_q;
   assign link.pin_prev[IDX] = prev_q;

endmodule : stp_ext_sync

`default_nettype wire

// ===== verilog/stp_top.sv
// Notes on behaviour
// - clock select 0x1 ticks the timer on every system clock.
// - divider offers taps at 8, 64, 256 and 1024 as tick sources.
// - one free-running divider serves both timers, whatever they select.
// - first divided tick after enable lands 1 to N+1 clocks later.
// - divider reset restarts the period for both timers alike.
// - count pins sampled each falling clock edge, then edge-detected.
// - input latch is transparent while clock high, holds while low.
// - select 0x7 ticks on rising pin edges, 0x6 on falling ones.
// - pin edge to tick takes 2.5 to 3.5 system clocks.
// - external pin ticks bypass the divider taps entirely.
// - sync mode bit set keeps both reset bits as written.
// - sync mode bit cleared makes hardware clear both reset bits.
// - timer two reset bit held; async mode waits for completion.
// - shared divider reset bit cleared at once unless sync mode.
// - control register at data offset 0x43, I/O address 0x23.
// - timer zero and timer one have independent clock selects.
`timescale 1ns/1ns
`default_nettype none
`include "stp_defines.svh"

module stp_top #(
   parameter int DIV_WIDTH = `STP_LOG2_DIV1024
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_IO,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   input wire logic [2:0] TIMER_ZERO_CLOCK_SELECT_FIELD,
   input wire logic [2:0] TIMER_ONE_CLOCK_SELECT_FIELD,
   input wire logic EXT_COUNT_PIN_ZERO,
   input wire logic EXT_COUNT_PIN_ONE,
   input wire logic TIMER_TWO_ASYNC_MODE,
   input wire logic TIMER_TWO_RESET_DONE,
   output logic TIMER_ZERO_TICK,
   output logic TIMER_ONE_TICK,
   output logic SYNC_PRESCALER_RESET,
   output logic ASYNC_PRESCALER_RESET
);

   if (DIV_WIDTH < `STP_LOG2_DIV1024) begin : g_width_check
      $error("stp_top: DIV_WIDTH too small for the /1024 tap");
   end

   stp_if link ();

   stp_divider #(
      .DIV_WIDTH(DIV_WIDTH)
   ) u_divider (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .link(link.div)
   );

   stp_ext_sync #(
      .IDX(0)
   ) u_ext_zero (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .pin(EXT_COUNT_PIN_ZERO),
      .link(link.ext)
   );

   stp_ext_sync #(
      .IDX(1)
   ) u_ext_one (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .pin(EXT_COUNT_PIN_ONE),
      .link(link.ext)
   );

   // tick source for one timer from its own clock_select_field
   function automatic logic pick_tick(
      input logic [2:0] cs,
      input stp_pkg::stp_taps_t taps,
      input logic level,
      input logic prev
   );
      logic tick;
      tick = 1'b0;
      case (stp_pkg::stp_clock_select_t'(cs))
         stp_pkg::CS_STOP: tick = 1'b0;
         stp_pkg::CS_DIRECT: tick = 1'b1;
         stp_pkg::CS_DIV8: tick = taps[`STP_TAP_DIV8];
         stp_pkg::CS_DIV64: tick = taps[`STP_TAP_DIV64];
         stp_pkg::CS_DIV256: tick = taps[`STP_TAP_DIV256];
         stp_pkg::CS_DIV1024: tick = taps[`STP_TAP_DIV1024];
         stp_pkg::CS_EXT_FALL: tick = prev & ~level;
         stp_pkg::CS_EXT_RISE: tick = level & ~prev;
         default: tick = 1'b0;
      endcase
      return tick;
   endfunction : pick_tick

   // register decode: data space or I/O space view
   logic reg_hit;
   logic reg_wr;
   logic reg_rd;

   always_comb begin
      if (REG_IO) begin
         reg_hit = (REG_ADDR == `STP_GTC_IO_OFFSET);
      end else if (REG_ADDR == `STP_GTC_DATA_OFFSET) begin
         reg_hit = 1'b1;
      end else begin
         reg_hit = 1'b0;
      end
   end

   assign reg_wr = REG_WR & reg_hit;
   assign reg_rd = REG_RD & reg_hit;

   logic sync_mode_q;
   logic async_busy;
   logic sync_reset_q;
   logic async_reset_q;

   // timer_sync_mode
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync_mode_q <= 1'(`STP_GTC_RESET >> `STP_GTC_SYNC_MODE_BIT);
      end else if (reg_wr) begin
         sync_mode_q <= REG_WDATA[`STP_GTC_SYNC_MODE_BIT];
      end
   end

   // sync_prescaler_reset: a write wins over the hardware clear
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sync_reset_q <= 1'b0;
      end else if (reg_wr) begin
         sync_reset_q <= REG_WDATA[`STP_GTC_SYNC_BIT];
      end else if (!sync_mode_q) begin
         sync_reset_q <= 1'b0;
      end
   end

   // async_prescaler_reset: a zero write cannot cut short a pending async reset
   assign async_busy = TIMER_TWO_ASYNC_MODE & ~TIMER_TWO_RESET_DONE;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         async_reset_q <= 1'b0;
      end else if (reg_wr && (REG_WDATA[`STP_GTC_ASYNC_BIT] || !async_busy)) begin
         async_reset_q <= REG_WDATA[`STP_GTC_ASYNC_BIT];
      end else if (!sync_mode_q && !async_busy) begin
         async_reset_q <= 1'b0;
      end
   end

   // the held bit keeps the shared divider at zero, halting divided taps
   assign link.presc_reset = sync_reset_q;

   assign SYNC_PRESCALER_RESET = sync_reset_q;
   assign ASYNC_PRESCALER_RESET = async_reset_q;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA <= 8'h00;
      end else if (reg_rd) begin
         REG_RDATA <= 8'h00;
         REG_RDATA[`STP_GTC_SYNC_MODE_BIT] <= sync_mode_q;
         REG_RDATA[`STP_GTC_ASYNC_BIT] <= async_reset_q;
         REG_RDATA[`STP_GTC_SYNC_BIT] <= sync_reset_q;
      end else begin
         REG_RDATA <= 8'h00;
      end
   end

   // tick flops double as the edge-detect output stage of the pin path
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         TIMER_ZERO_TICK <= 1'b0;
         TIMER_ONE_TICK <= 1'b0;
      end else begin
         TIMER_ZERO_TICK <= pick_tick(TIMER_ZERO_CLOCK_SELECT_FIELD, link.tap,
                                      link.pin_sync[0], link.pin_prev[0]);
         TIMER_ONE_TICK <= pick_tick(TIMER_ONE_CLOCK_SELECT_FIELD, link.tap,
                                     link.pin_sync[1], link.pin_prev[1]);
      end
   end

endmodule : stp_top

`default_nettype wire

// ===== tb/stp_ext_src.sv
`timescale 1ns/1ns
`default_nettype none
module stp_ext_src (
   input wire logic clk,
   input wire logic en,
   output logic pin
);
   int n = 0;
   logic late = 1'b0;
   initial pin = 1'b0;
   // toggles every 3 clocks, alternately in the high and the low phase
   always @(posedge clk) begin
      if (en) begin
         n = n + 1;
         if (n == 3) begin
            n = 0;
            late = ~late;
            pin <= #(late ? 7 : 3) ~pin;
         end
      end
   end
endmodule : stp_ext_src
`default_nettype wire

// ===== tb/stp_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
module stp_top_sva #(parameter int DIV_WIDTH = 10) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic REG_IO,
   input wire logic REG_WR,
   input wire logic EXT_COUNT_PIN_ZERO,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic [2:0] TIMER_ZERO_CLOCK_SELECT_FIELD,
   input wire logic [2:0] TIMER_ONE_CLOCK_SELECT_FIELD,
   input wire logic TIMER_TWO_ASYNC_MODE,
   input wire logic TIMER_TWO_RESET_DONE,
   input wire logic TIMER_ZERO_TICK,
   input wire logic TIMER_ONE_TICK,
   input wire logic SYNC_PRESCALER_RESET,
   input wire logic ASYNC_PRESCALER_RESET
);
   wire logic [2:0] c0 = TIMER_ZERO_CLOCK_SELECT_FIELD;
   wire logic [2:0] c1 = TIMER_ONE_CLOCK_SELECT_FIELD;
   wire logic wr = REG_WR && (REG_IO ? REG_ADDR == 8'h23 : REG_ADDR == 8'h43);
   logic [1:0] up_q;
   logic mode_q;
   wire logic on = up_q == 2'h3;
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         up_q <= 2'h0;
      end else if (!on) begin
         up_q <= up_q + 2'h1;
      end
   end
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q <= 1'b0;
      end else if (wr) begin
         mode_q <= REG_WDATA[7];
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   direct_tick_a: assert property (on && $past(c0) == 3'h1 |-> TIMER_ZERO_TICK)
      else $error("direct tick missing");
   div_period_a: assert property ((TIMER_ONE_TICK && c1 == 3'h2 && !SYNC_PRESCALER_RESET) ##1
      (c1 == 3'h2 && !SYNC_PRESCALER_RESET && !REG_WR)[*8]
      |-> TIMER_ONE_TICK && !$past(TIMER_ONE_TICK)) else $error("divide by 8 period");
   ext_rise_a: assert property (on && $rose(EXT_COUNT_PIN_ZERO) && c0 == 3'h7
      |-> ##[3:4] TIMER_ZERO_TICK) else $error("pin edge latency");
   ext_quiet_a: assert property (on && $fell(EXT_COUNT_PIN_ZERO) && c0 == 3'h7
      |-> ##3 !TIMER_ZERO_TICK ##1 !TIMER_ZERO_TICK) else $error("tick on wrong edge");
   sync_pulse_a: assert property (wr && REG_WDATA == 8'h01 ##1 !REG_WR
      |-> SYNC_PRESCALER_RESET ##1 !SYNC_PRESCALER_RESET) else $error("reset bit pulse");
   mode_hold_a: assert property (mode_q && !wr |=> $stable(SYNC_PRESCALER_RESET)
      && $stable(ASYNC_PRESCALER_RESET)) else $error("reset bits not held");
   mode_clear_a: assert property (mode_q && wr && REG_WDATA == 8'h00
      |=> !SYNC_PRESCALER_RESET) else $error("reset bit not cleared");
   async_wait_a: assert property (ASYNC_PRESCALER_RESET && TIMER_TWO_ASYNC_MODE
      && !TIMER_TWO_RESET_DONE && !REG_WR |=> ASYNC_PRESCALER_RESET)
      else $error("async reset bit dropped");
endmodule : stp_top_sva
bind stp_top stp_top_sva #(.DIV_WIDTH(DIV_WIDTH)) chk (
   .REF_CLK(REF_CLK),
   .RST_N(RST_N),
   .REG_IO(REG_IO),
   .REG_WR(REG_WR),
   .EXT_COUNT_PIN_ZERO(EXT_COUNT_PIN_ZERO),
   .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA),
   .TIMER_ZERO_CLOCK_SELECT_FIELD(TIMER_ZERO_CLOCK_SELECT_FIELD),
   .TIMER_ONE_CLOCK_SELECT_FIELD(TIMER_ONE_CLOCK_SELECT_FIELD),
   .TIMER_TWO_ASYNC_MODE(TIMER_TWO_ASYNC_MODE),
   .TIMER_TWO_RESET_DONE(TIMER_TWO_RESET_DONE),
   .TIMER_ZERO_TICK(TIMER_ZERO_TICK),
   .TIMER_ONE_TICK(TIMER_ONE_TICK),
   .SYNC_PRESCALER_RESET(SYNC_PRESCALER_RESET),
   .ASYNC_PRESCALER_RESET(ASYNC_PRESCALER_RESET)
);
`default_nettype wire

// ===== tb/shared_timer_prescaler_tb.sv
`timescale 1ns/1ns
`default_nettype none
module shared_timer_prescaler_tb;
   typedef struct {logic [2:0] a; logic [2:0] b; logic [15:0] e0; logic [15:0] e1;} stp_row_t;
   stp_row_t rows [4] = '{'{3'h1, 3'h0, 16'h400, 16'h0}, '{3'h3, 3'h2, 16'h10, 16'h80},
      '{3'h4, 3'h5, 16'h4, 16'h1}, '{3'h0, 3'h1, 16'h0, 16'h400}};
   logic clk = 1'b0, rst_n = 1'b0, io = 1'b0, wr = 1'b0, rd = 1'b0;
   logic amode = 1'b0, done = 1'b0, en = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [2:0] cs0 = 3'h0, cs1 = 3'h0;
   logic pin0, pin1, t0, t1, srst, arst;
   int errors = 0, num_checks = 0, n0 = 0, n1 = 0, k;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (t0 === 1'b1) n0++;
      if (t1 === 1'b1) n1++;
   end
   stp_ext_src src0 (.clk(clk), .en(en), .pin(pin0));
   stp_ext_src src1 (.clk(clk), .en(en), .pin(pin1));
   stp_top #(.DIV_WIDTH(10)) dut (.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_IO(io),
      .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
      .TIMER_ZERO_CLOCK_SELECT_FIELD(cs0), .TIMER_ONE_CLOCK_SELECT_FIELD(cs1),
      .EXT_COUNT_PIN_ZERO(pin0), .EXT_COUNT_PIN_ONE(pin1), .TIMER_TWO_ASYNC_MODE(amode),
      .TIMER_TWO_RESET_DONE(done), .TIMER_ZERO_TICK(t0), .TIMER_ONE_TICK(t1),
      .SYNC_PRESCALER_RESET(srst), .ASYNC_PRESCALER_RESET(arst));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input logic [7:0] a, input logic i, input logic w, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      io = i;
      wr = w;
      rd = !w;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
      rd = 1'b0;
   endtask : acc
   task automatic conclude();
      if (errors == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   initial begin
      #200000;
      errors++;
      conclude();
   end
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      acc(8'h43, 1'b0, 1'b0, 8'h00);
      check(16'(rdata), 16'h0);
      foreach (rows[i]) begin
         cs0 = rows[i].a;
         cs1 = rows[i].b;
         repeat (2) @(negedge clk);
         n0 = 0;
         n1 = 0;
         repeat (1024) @(negedge clk);
         check(16'(n0), rows[i].e0);
         check(16'(n1), rows[i].e1);
      end
      amode = 1'b1;
      acc(8'h44, 1'b0, 1'b1, 8'h83);
      acc(8'h23, 1'b1, 1'b0, 8'h00);
      check(16'(rdata), 16'h0);
      acc(8'h43, 1'b0, 1'b1, 8'h01);
      check(16'(srst), 16'h1);
      @(negedge clk);
      check(16'(srst), 16'h0);
      cs0 = 3'h1;
      cs1 = 3'h2;
      acc(8'h23, 1'b1, 1'b1, 8'h83);
      n0 = 0;
      n1 = 0;
      repeat (64) @(negedge clk);
      check(16'(n1), 16'h0);
      check(16'(n0), 16'h40);
      acc(8'h23, 1'b1, 1'b0, 8'h00);
      check(16'(rdata), 16'h83);
      cs0 = 3'h2;
      acc(8'h43, 1'b0, 1'b1, 8'h00);
      check(16'({srst, arst}), 16'h1);
      k = 0;
      while (t1 !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      check(16'(k >= 1 && k <= 9), 16'h1);
      check(16'(t0), 16'(t1));
      check(16'(arst), 16'h1);
      done = 1'b1;
      @(negedge clk);
      @(negedge clk);
      check(16'(arst), 16'h0);
      done = 1'b0;
      amode = 1'b0;
      cs0 = 3'h7;
      cs1 = 3'h6;
      @(negedge clk);
      n0 = 0;
      n1 = 0;
      en = 1'b1;
      repeat (600) @(negedge clk);
      en = 1'b0;
      repeat (10) @(negedge clk);
      check(16'(n0), 16'h64);
      check(16'(n1), 16'h64);
      acc(8'h43, 1'b0, 1'b1, 8'h83);
      rst_n = 1'b0;
      @(negedge clk);
      check(16'({srst, arst}), 16'h0);
      rst_n = 1'b1;
      acc(8'h43, 1'b0, 1'b0, 8'h00);
      check(16'(rdata), 16'h0);
      conclude();
   end
endmodule : shared_timer_prescaler_tb
`default_nettype wire
